// ==== include/fvc_pkg.sv ====
package fvc_pkg;

  // Volatile read configuration fields.
  localparam int VRC_DUMMY_HI = 7;
  localparam int VRC_DUMMY_LO = 4;
  localparam int VRC_DXM_BIT  = 3;
  localparam int VRC_RSV_BIT  = 2;
  localparam int VRC_WRAP_HI  = 1;
  localparam int VRC_WRAP_LO  = 0;

  // Enhanced volatile configuration fields.
  localparam int EVC_QUAD_BIT = 7;
  localparam int EVC_DUAL_BIT = 6;
  localparam int EVC_RSV_BIT  = 5;
  localparam int EVC_HOLD_BIT = 4;
  localparam int EVC_ACC_BIT  = 3;
  localparam int EVC_DRV_HI   = 2;
  localparam int EVC_DRV_LO   = 0;

  // Nonvolatile protocol bits sampled at power-on.
  localparam int NVC_DUAL_BIT = 2;
  localparam int NVC_QUAD_BIT = 3;

  localparam logic [7:0] VRC_RESET = 8'hfb;
  localparam logic [7:0] EVC_RESET = 8'hdf;

  localparam logic [3:0] DUMMY_CODE_ZERO = 4'h0;
  localparam logic [3:0] DUMMY_CODE_DFLT = 4'hf;
  // Default count, sized for the fastest read type at the top clock.
  localparam logic [3:0] DUMMY_DEFAULT   = 4'ha;

  localparam logic [1:0] WRAP_16  = 2'h0;
  localparam logic [1:0] WRAP_32  = 2'h1;
  localparam logic [1:0] WRAP_64  = 2'h2;
  localparam logic [1:0] WRAP_SEQ = 2'h3;

  typedef enum logic [2:0] {
    FVC_PROTO_EXT  = 3'b001,
    FVC_PROTO_DUAL = 3'b010,
    FVC_PROTO_QUAD = 3'b100
  } fvc_proto_t;

endpackage

// ==== src/fvc_wrap_addr.sv ====
`timescale 1ns/10ps
// Next read address, held inside the aligned window that wrap codes 00/01/10 select; code 11 steps on with no window.
module fvc_wrap_addr #(
  parameter int AW = 24
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [1:0]    wrap,
  output logic      [AW-1:0] next_addr
);
  import fvc_pkg::*;

  localparam int AW_MIN = 7;

  if (AW < AW_MIN) begin : g_aw_check
    $error("fvc_wrap_addr: AW must cover a 64-byte window");
  end

  logic [AW-1:0] inc;
  logic [AW-1:0] mask;

  always_comb begin
    inc = addr + {{(AW-1){1'b0}}, 1'b1};
    case (wrap)
      WRAP_16: mask = {{(AW-4){1'b0}}, 4'hf};
      WRAP_32: mask = {{(AW-5){1'b0}}, 5'h1f};
      WRAP_64: mask = {{(AW-6){1'b0}}, 6'h3f};
      default: mask = '0;
    endcase
    if (wrap == WRAP_SEQ) begin
      next_addr = inc; // R11
    end else begin
      next_addr = (addr & ~mask) | (inc & mask); // R10
    end
  end

endmodule // fvc_wrap_addr

// ==== src/fvc_config_regs.sv ====
`timescale 1ns/10ps
// What this block and its host do
// R1 - Both nonvolatile protocol bits low: quad at power-on
// R2 - Nonvolatile protocol choice applies only at power-on
// R3 - Volatile bits 7:4 set fast-read dummy cycles
// R4 - Dummy codes 0000 and 1111 both give default
// R5 - Host sizes dummy count for its clock
// R6 - Host keeps clock within dummy-count limit
// R7 - Volatile bit 3 low enables direct execute
// R8 - Some variants always run direct execute mode
// R9 - Volatile reserved bit 2 always reads zero
// R10 - Wrap codes 00/01/10 bound reads to 16/32/64
// R11 - Wrap code 11 reads sequentially without wrap
// R12 - Writes take effect at once, command only
// R13 - Enhanced bit 7 low selects quad protocol
// R14 - Enhanced bit 6 low selects dual protocol
// R15 - Enhanced bit 4 enables hold or reset pin
// R16 - Enhanced bit 3 low enables supply acceleration
// R17 - Bits 6,7 both low quad; 6 alone dual
// R18 - Power-on loads documented volatile defaults
module fvc_config_regs #(
  parameter int  AW         = 24,
  parameter bit  FORCE_DXM  = 1'b0,
  parameter bit  HAS_HOLD   = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [7:0]        nvc_proto_bits,
  input  wire logic              vrc_wr,
  input  wire logic              evc_wr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              addr_load,
  input  wire logic              addr_step,
  input  wire logic [AW-1:0]     start_addr,
  output logic      [7:0]        vrc_rd_data,
  output logic      [7:0]        evc_rd_data,
  output logic      [3:0]        dummy_cycles,
  output logic                   direct_execute_mode,
  output logic      [1:0]        wrap_mode,
  output fvc_pkg::fvc_proto_t    protocol,
  output logic                   hold_reset_en,
  output logic                   supply_accel_en,
  output logic      [2:0]        drive_strength,
  output logic      [AW-1:0]     read_addr
);
  import fvc_pkg::*;

  // The largest wrap window is 64 bytes, so the address needs six low bits
  // below at least one upper bit that the window keeps.
  localparam int AW_MIN = 7;

  if (AW < AW_MIN) begin : g_aw_check
    $error("fvc_config_regs: AW must cover a 64-byte window");
  end

  function automatic fvc_proto_t proto_of(input logic quad_n,
                                          input logic dual_n);
    if (!quad_n) begin
      proto_of = FVC_PROTO_QUAD;
    end else if (!dual_n) begin
      proto_of = FVC_PROTO_DUAL;
    end else begin
      proto_of = FVC_PROTO_EXT;
    end
  endfunction

  // Codes 0000 and 1111 are aliases; both give the default count.
  function automatic logic [3:0] dummy_of(input logic [3:0] code);
    if (code == DUMMY_CODE_ZERO || code == DUMMY_CODE_DFLT) begin
      dummy_of = DUMMY_DEFAULT; // R4
    end else begin
      dummy_of = code; // R3
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]    vrc_q;
  logic [7:0]    evc_q;
  logic [7:0]    nvc_s1_q;
  logic [7:0]    nvc_s2_q;
  logic [1:0]    boot_cnt_q;
  logic          boot_capture;
  logic [3:0]    dummy_q;
  logic          dxm_q;
  logic          hold_q;
  logic          accel_q;
  fvc_proto_t    proto_q;
  fvc_proto_t    proto_d;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_next;

  // The nonvolatile image is static, but it arrives from another block,
  // so it is synchronised before the single power-on capture.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nvc_s1_q <= 8'hff;
      nvc_s2_q <= 8'hff;
    end else begin
      nvc_s1_q <= nvc_proto_bits;
      nvc_s2_q <= nvc_s1_q;
    end
  end

  // The second synchroniser stage still shows its reset value at the first
  // edge after release; it holds a real sample only from the second edge.
  // Capturing any earlier would always boot in extended mode.
  localparam logic [1:0] BOOT_CAPTURE = 2'h2;
  localparam logic [1:0] BOOT_DONE    = 2'h3;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot_cnt_q <= 2'h0;
    end else if (boot_cnt_q != BOOT_DONE) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end

  assign boot_capture = (boot_cnt_q == BOOT_CAPTURE); // R2

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vrc_q <= VRC_RESET; // R18
    end else if (vrc_wr) begin
      vrc_q <= wr_data; // R12
      vrc_q[VRC_RSV_BIT] <= 1'b0; // R9
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evc_q <= EVC_RESET;
    end else if (evc_wr) begin
      evc_q <= wr_data; // R12
      evc_q[EVC_RSV_BIT] <= 1'b0;
    end
  end

  // Protocol is taken once from nonvolatile bits after reset release unless an
  // enhanced register write falls in that cycle and wins; then it follows each write.
  always_comb begin
    proto_d = proto_q;
    if (evc_wr) begin
      proto_d = proto_of(wr_data[EVC_QUAD_BIT],
                         wr_data[EVC_DUAL_BIT]); // R13 R14 R17
    end else if (boot_capture) begin
      proto_d = proto_of(nvc_s2_q[NVC_QUAD_BIT],
                         nvc_s2_q[NVC_DUAL_BIT]); // R1 R2
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      proto_q <= FVC_PROTO_EXT;
    end else begin
      proto_q <= proto_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Derived settings are decoded from the written byte and registered in
  // the same edge as the register itself, so they change together with it
  // and every data output comes straight from a flip-flop.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dummy_q <= DUMMY_DEFAULT; // R18
      dxm_q   <= FORCE_DXM;
    end else if (vrc_wr) begin
      dummy_q <= dummy_of(wr_data[VRC_DUMMY_HI:VRC_DUMMY_LO]); // R3 R4
      // Forced variants ignore the enable bit entirely.
      dxm_q   <= FORCE_DXM | ~wr_data[VRC_DXM_BIT]; // R7 R8
    end
  end

  // Variants without the pin keep the function off whatever is written.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_q  <= HAS_HOLD & EVC_RESET[EVC_HOLD_BIT];
      accel_q <= ~EVC_RESET[EVC_ACC_BIT];
    end else if (evc_wr) begin
      hold_q  <= HAS_HOLD & wr_data[EVC_HOLD_BIT]; // R15
      accel_q <= ~wr_data[EVC_ACC_BIT]; // R16
    end
  end

  assign dummy_cycles        = dummy_q;
  assign direct_execute_mode = dxm_q;
  assign wrap_mode           = vrc_q[VRC_WRAP_HI:VRC_WRAP_LO];
  assign protocol            = proto_q;
  assign hold_reset_en       = hold_q;
  assign supply_accel_en     = accel_q;
  assign drive_strength      = evc_q[EVC_DRV_HI:EVC_DRV_LO];
  assign vrc_rd_data         = vrc_q;
  assign evc_rd_data         = evc_q;

  ////////////////////////////////////////////////////////////////////////////

  fvc_wrap_addr #(
    .AW        (AW)
  ) u_wrap (
    .addr      (addr_q),
    .wrap      (vrc_q[VRC_WRAP_HI:VRC_WRAP_LO]),
    .next_addr (addr_next)
  );

  // A load wins over a step in the same cycle, so a new read always starts
  // exactly at the issued address.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_q <= '0;
    end else if (addr_load) begin
      addr_q <= start_addr;
    end else if (addr_step) begin
      addr_q <= addr_next; // R10 R11
    end
  end

  assign read_addr = addr_q;

endmodule // fvc_config_regs

// ==== sim/fvc_chk.sv ====
`timescale 1ns/10ps
module fvc_chk (
  input wire logic                clk_sys,
  input wire logic                rstn,
  input wire logic                vrc_wr,
  input wire logic                evc_wr,
  input wire logic [7:0]          wr_data,
  input wire logic [7:0]          vrc_rd_data,
  input wire logic [7:0]          evc_rd_data,
  input wire logic [3:0]          dummy_cycles,
  input wire logic                direct_execute_mode,
  input wire logic [1:0]          wrap_mode,
  input wire fvc_pkg::fvc_proto_t protocol,
  input wire logic                hold_reset_en,
  input wire logic                supply_accel_en
);
  import fvc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  property p_vw;
    vrc_wr |=> vrc_rd_data == ($past(wr_data) & 8'hfb);
  endproperty
  a_vw: assert property (p_vw) else $error("vrc write bad");
  property p_ew;
    evc_wr |=> evc_rd_data == ($past(wr_data) & 8'hdf);
  endproperty
  a_ew: assert property (p_ew) else $error("evc write bad");
  property p_pr;
    evc_wr |=> protocol == (!$past(wr_data[7]) ? FVC_PROTO_QUAD :
      !$past(wr_data[6]) ? FVC_PROTO_DUAL : FVC_PROTO_EXT);
  endproperty
  a_pr: assert property (p_pr) else $error("protocol bad");
  property p_st; !vrc_wr |=> $stable(vrc_rd_data); endproperty
  a_st: assert property (p_st) else $error("vrc moved");
  property p_du; dummy_cycles == (vrc_rd_data[7:4] inside {4'h0, 4'hf} ?
    4'ha : vrc_rd_data[7:4]); endproperty
  a_du: assert property (p_du) else $error("dummy bad");
  property p_dx; direct_execute_mode == !vrc_rd_data[3]; endproperty
  a_dx: assert property (p_dx) else $error("dxm bad");
  property p_wr; wrap_mode == vrc_rd_data[1:0]; endproperty
  a_wr: assert property (p_wr) else $error("wrap bad");
  property p_ha; {hold_reset_en, supply_accel_en} ==
    {evc_rd_data[4], !evc_rd_data[3]}; endproperty
  a_ha: assert property (p_ha) else $error("hold or accel bad");
  cover property (protocol == FVC_PROTO_QUAD);
  cover property (vrc_wr && wr_data[7:4] == 4'h0);
  cover property (evc_wr && wr_data[7:6] == 2'h2);
endmodule // fvc_chk

// ==== sim/fvc_host_model.sv ====
`timescale 1ns/10ps
module fvc_host_model (
  input  wire logic        clk_sys,
  output logic             vrc_wr,
  output logic             evc_wr,
  output logic [7:0]       wr_data,
  output logic             addr_load,
  output logic             addr_step,
  output logic [23:0]      start_addr
);
  initial begin
    {vrc_wr, evc_wr, addr_load, addr_step} = 4'h0;
    wr_data = 8'h00;
    start_addr = 24'h00_0000;
  end
  // Strobes are 8 vrc, 4 evc, 2 load, 1 step; stale values are inverted.
  task automatic op(input logic [3:0] s, input logic [23:0] v);
    @(posedge clk_sys);
    #1 {vrc_wr, evc_wr, addr_load, addr_step} = s;
    wr_data = v[7:0];
    start_addr = v;
    @(posedge clk_sys);
    #1 {vrc_wr, evc_wr, addr_load, addr_step} = 4'h0;
    wr_data = ~v[7:0];
    start_addr = ~v;
  endtask
endmodule // fvc_host_model

// ==== sim/test_flash_volatile_config_regs.sv ====
`timescale 1ns/10ps
module test_flash_volatile_config_regs;
  import fvc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  nvc_proto_bits = 8'hf3;
  logic        vrc_wr, evc_wr, addr_load, addr_step;
  logic [7:0]  wr_data, vrc_rd_data, evc_rd_data;
  logic [23:0] start_addr, read_addr;
  logic [3:0]  dummy_cycles;
  logic [1:0]  wrap_mode;
  logic [2:0]  drive_strength;
  logic        direct_execute_mode, hold_reset_en, supply_accel_en;
  fvc_proto_t  protocol;
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  fvc_host_model fvc_host_model_i (.*);
  fvc_config_regs fvc_config_regs_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_boot;
    chk("proto", protocol, FVC_PROTO_QUAD);
    chk("vrc", vrc_rd_data, 8'hfb);
    chk("evc", evc_rd_data, 8'hdf);
    chk("dummy", dummy_cycles, 4'ha);
    chk("dxm", direct_execute_mode, 1'b0);
    chk("wrap", wrap_mode, 2'h3);
    chk("hold", hold_reset_en, 1'b1);
    chk("accel", supply_accel_en, 1'b0);
    nvc_proto_bits = 8'hfb;
    repeat (4) @(posedge clk_sys);
    #1 chk("proto held", protocol, FVC_PROTO_QUAD);
    $display("t_boot done");
  endtask
  task automatic t_vrc;
    fvc_host_model_i.op(4'h8, 24'h51);
    chk("vrc", vrc_rd_data, 8'h51);
    chk("dummy", dummy_cycles, 4'h5);
    chk("dxm", direct_execute_mode, 1'b1);
    fvc_host_model_i.op(4'h8, 24'h0c);
    chk("rsv", vrc_rd_data, 8'h08);
    chk("dummy0", dummy_cycles, 4'ha);
    chk("dxm off", direct_execute_mode, 1'b0);
    $display("t_vrc done");
  endtask
  task automatic t_wrap;
    logic [23:0] ex [4] = '{24'h30, 24'h20, 24'h00, 24'h40};
    for (int w = 0; w < 4; w++) begin
      fvc_host_model_i.op(4'h8, 24'(8'hf0 + w));
      fvc_host_model_i.op(4'h2, 24'h3f);
      chk("load", read_addr, 24'h3f);
      fvc_host_model_i.op(4'h1, 24'h00);
      chk("step", read_addr, ex[w]);
    end
    $display("t_wrap done");
  endtask
  task automatic t_evc;
    logic [7:0] d [4] = '{8'h3f, 8'hbf, 8'h7f, 8'he2};
    for (int i = 0; i < 4; i++) begin
      fvc_host_model_i.op(4'h4, 24'(d[i]));
      chk("evc", evc_rd_data, d[i] & 8'hdf);
      chk("proto", protocol, !d[i][7] ? FVC_PROTO_QUAD :
        !d[i][6] ? FVC_PROTO_DUAL : FVC_PROTO_EXT);
      chk("hold", hold_reset_en, d[i][4]);
      chk("accel", supply_accel_en, !d[i][3]);
      chk("drive", drive_strength, d[i][2:0]);
    end
    $display("t_evc done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 t_boot;
    t_vrc;
    t_wrap;
    t_evc;
    test_done;
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule // test_flash_volatile_config_regs
bind fvc_config_regs fvc_chk fvc_chk_i (.*);
